/* File: dv/serial_frame_assertions.sv */
// Port checks for the serial frame transmitter.
module serial_frame_checker (
	// Clock, reset and inputs.
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic tx_en_i,
	input wire logic sync_mode_sel_i,
	input wire logic clock_master_sel_i,
	input wire logic clock_polarity_sel_i,
	input wire logic data_valid_i,
	input wire logic rx_stop_valid_i,
	input wire logic rx_first_stop_i,
	// Outputs watched.
	input wire logic data_ready_o,
	input wire logic buf_empty_o,
	input wire logic tx_busy_o,
	input wire logic tx_done_flag_o,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe_o,
	input wire logic transfer_clock_pin_o,
	input wire logic transfer_clock_pin_oe_o,
	input wire logic framing_error_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	ready_off_a: assert property (!tx_en_i |=> !data_ready_o)
		else $error("ready while disabled");
	write_fills_a: assert property (data_valid_i && data_ready_o |=> !buf_empty_o)
		else $error("buffer empty after write");
	queued_busy_a: assert property (!buf_empty_o |-> tx_busy_o)
		else $error("queued char but not busy");
	idle_high_a: assert property (!tx_busy_o |-> serial_out_pin_o)
		else $error("idle line not high");
	pin_owned_a: assert property (tx_en_i |=> serial_out_pin_oe_o)
		else $error("line not driven");
	fe_follow_a: assert property (rx_stop_valid_i |=> framing_error_o == !$past(rx_first_stop_i))
		else $error("framing error wrong");
	fe_hold_a: assert property (!rx_stop_valid_i |=> $stable(framing_error_o))
		else $error("framing error moved");
	start_len_a: assert property ($fell(serial_out_pin_o) && !sync_mode_sel_i |-> !serial_out_pin_o [*8])
		else $error("start bit short");
	clk_pin_a: assert property (1'b1 |=> transfer_clock_pin_oe_o == $past(sync_mode_sel_i && clock_master_sel_i))
		else $error("clock pin ownership wrong");
	sync_edge_a: assert property (sync_mode_sel_i && clock_master_sel_i &&
		$changed(serial_out_pin_o) |-> transfer_clock_pin_o != clock_polarity_sel_i)
		else $error("sync data changed on wrong clock edge");
	cover property (data_valid_i && data_ready_o);
	cover property ($rose(tx_done_flag_o));
	cover property ($rose(framing_error_o));
endmodule
bind serial_frame_transmitter serial_frame_checker u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .tx_en_i(tx_en_i), .sync_mode_sel_i(sync_mode_sel_i),
	.clock_master_sel_i(clock_master_sel_i), .clock_polarity_sel_i(clock_polarity_sel_i),
	.data_valid_i(data_valid_i), .transfer_clock_pin_o(transfer_clock_pin_o),
	.rx_stop_valid_i(rx_stop_valid_i), .rx_first_stop_i(rx_first_stop_i),
	.data_ready_o(data_ready_o), .buf_empty_o(buf_empty_o), .tx_busy_o(tx_busy_o),
	.tx_done_flag_o(tx_done_flag_o), .serial_out_pin_o(serial_out_pin_o),
	.serial_out_pin_oe_o(serial_out_pin_oe_o), .framing_error_o(framing_error_o),
	.transfer_clock_pin_oe_o(transfer_clock_pin_oe_o)
);

/* File: dv/serial_line_model.sv */
// Receiving model of the far end of the serial line.
module serial_line_model (
	// Clock and line.
	input wire logic clk_i,
	input wire logic line_i,
	// Frame shape expected.
	input wire logic [3:0] nbits_i,
	input wire logic par_en_i,
	input wire logic two_stop_i,
	input wire logic [4:0] bit_len_i,
	// Last frame seen.
	output int count_o,
	output logic [8:0] data_o,
	output logic par_o,
	output logic [1:0] stop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic hop(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Samples mid-bit, so a bit of the wrong length corrupts the frame.
	initial begin
		count_o = 0;
		forever begin
			@(negedge line_i);
			hop(bit_len_i / 2);
			data_o = 9'h000;
			par_o = 1'h0;
			stop_o = 2'h3;
			for (int i = 0; i < nbits_i; i++) begin
				hop(bit_len_i);
				data_o[i] = line_i;
			end
			if (par_en_i) begin
				hop(bit_len_i);
				par_o = line_i;
			end
			hop(bit_len_i);
			stop_o[0] = line_i;
			if (two_stop_i) begin
				hop(bit_len_i);
				stop_o[1] = line_i;
			end
			count_o++;
		end
	end
endmodule

/* File: dv/test_serial_frame_transmitter.sv */
// Self-checking bench for the serial frame transmitter.
module test_serial_frame_transmitter;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'h0;
	logic rst_i = 1'h1;
	logic tx_en_i = 1'h0;
	logic [2:0] char_size_sel_i = 3'h0;
	logic [1:0] parity_mode_sel_i = 2'h0;
	logic two_stop_sel_i = 1'h0;
	logic double_speed_sel_i = 1'h0;
	logic baud_divisor_load_i = 1'h0;
	logic sync_mode_sel_i = 1'h0;
	logic clock_master_sel_i = 1'h0;
	logic clock_polarity_sel_i = 1'h0;
	logic [11:0] baud_divisor_i = 12'h000;
	logic transfer_clock_pin_o, transfer_clock_pin_oe_o;
	logic [1:0] ext_div = 2'h0;
	logic ext_clk = 1'h0;
	logic data_valid_i = 1'h0;
	logic [7:0] data_buffer_port_i = 8'h00;
	logic tx_ninth_bit_i = 1'h0;
	logic tx_done_clr_i = 1'h0;
	logic rx_stop_valid_i = 1'h0;
	logic rx_first_stop_i = 1'h1;
	logic data_ready_o, buf_empty_o, tx_done_flag_o, tx_busy_o;
	logic serial_out_pin_o, serial_out_pin_oe_o, framing_error_o, rx_par;
	logic [3:0] nbits = 4'h8;
	logic [4:0] blen = 5'h10;
	logic [8:0] rx_data;
	logic [1:0] rx_stop;
	int rx_count;
	int failures = 0;
	int checks = 0;
	// Size code, parity mode, two stops, double speed.
	logic [6:0] cfg [5] = '{7'h00, 7'h1A, 7'h2D, 7'h38, 7'h7E};
	always #2 mclk_i = ~mclk_i;
	// Slave transfer clock with a period of eight system clocks.
	always @(posedge mclk_i) begin
		ext_div <= ext_div + 2'h1;
		if (ext_div == 2'h3)
			ext_clk <= ~ext_clk;
	end
	serial_frame_transmitter u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .tx_en_i(tx_en_i),
		.char_size_sel_i(char_size_sel_i), .parity_mode_sel_i(parity_mode_sel_i),
		.two_stop_sel_i(two_stop_sel_i), .double_speed_sel_i(double_speed_sel_i),
		.sync_mode_sel_i(sync_mode_sel_i), .clock_master_sel_i(clock_master_sel_i),
		.clock_polarity_sel_i(clock_polarity_sel_i),
		.baud_divisor_i(baud_divisor_i), .baud_divisor_load_i(baud_divisor_load_i),
		.data_valid_i(data_valid_i), .data_buffer_port_i(data_buffer_port_i),
		.tx_ninth_bit_i(tx_ninth_bit_i), .data_ready_o(data_ready_o),
		.buf_empty_o(buf_empty_o), .tx_done_flag_o(tx_done_flag_o),
		.tx_done_clr_i(tx_done_clr_i), .tx_busy_o(tx_busy_o),
		.serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
		.transfer_clock_pin_i(ext_clk), .transfer_clock_pin_o(transfer_clock_pin_o),
		.transfer_clock_pin_oe_o(transfer_clock_pin_oe_o),
		.rx_stop_valid_i(rx_stop_valid_i), .rx_first_stop_i(rx_first_stop_i),
		.framing_error_o(framing_error_o)
	);
	serial_line_model u_far (
		.clk_i(mclk_i), .line_i(serial_out_pin_o), .nbits_i(nbits),
		.par_en_i(parity_mode_sel_i[1]), .two_stop_i(two_stop_sel_i), .bit_len_i(blen),
		.count_o(rx_count), .data_o(rx_data), .par_o(rx_par), .stop_o(rx_stop)
	);
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Holds the request until k copies are taken on ready edges.
	task automatic put(input logic [8:0] c, input int k);
		int n;
		n = 0;
		data_valid_i <= 1'h1;
		data_buffer_port_i <= c[7:0];
		tx_ninth_bit_i <= c[8];
		while (k > 0 && n < 2000) begin
			@(posedge mclk_i);
			n++;
			if (data_ready_o === 1'h1)
				k--;
		end
		if (k > 0)
			failures++;
		data_valid_i <= 1'h0;
		tx_ninth_bit_i <= ~c[8];
	endtask
	task automatic frames(input logic [8:0] c, input int k);
		logic [8:0] m;
		logic p;
		int n;
		int b;
		m = 9'h1FF >> (4'h9 - nbits);
		p = parity_mode_sel_i[1] & (^(c & m) ^ parity_mode_sel_i[0]);
		n = 0;
		b = rx_count;
		repeat (k) begin
			b++;
			while (rx_count < b && n < 9000) begin
				@(posedge mclk_i);
				n++;
			end
			if (rx_count < b)
				failures++;
			check(rx_data, c & m);
			check({6'h00, p, rx_stop}, {6'h00, rx_par, 2'h3});
		end
	endtask
	initial begin
		step(20000);
		failures++;
		wrap_up();
	end
	initial begin
		logic [8:0] c;
		logic x;
		step(16);
		check({4'h0, buf_empty_o, tx_done_flag_o, serial_out_pin_o, serial_out_pin_oe_o,
			data_ready_o}, 9'h014);
		rst_i <= 1'h0;
		tx_en_i <= 1'h1;
		baud_divisor_load_i <= 1'h1;
		step(1);
		baud_divisor_load_i <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			{char_size_sel_i, parity_mode_sel_i, two_stop_sel_i, double_speed_sel_i} <= cfg[i];
			nbits = (cfg[i][6:4] == 3'h7) ? 4'h9 : {1'h0, cfg[i][6:4]} + 4'h5;
			blen = cfg[i][0] ? 5'h08 : 5'h10;
			c = 9'h1A5 ^ (9'h0C3 << i);
			step(2);
			put(c, 2);
			frames(c, 2);
			step(blen);
			check({5'h00, tx_done_flag_o, buf_empty_o, tx_busy_o, serial_out_pin_o}, 9'h00D);
			tx_done_clr_i <= 1'h1;
			step(1);
			tx_done_clr_i <= 1'h0;
			step(1);
			check({8'h00, tx_done_flag_o}, 9'h000);
		end
		sync_mode_sel_i <= 1'h1;
		baud_divisor_i <= 12'h001;
		{char_size_sel_i, parity_mode_sel_i, two_stop_sel_i, double_speed_sel_i} <= 7'h3C;
		nbits = 4'h8;
		c = 9'h05A;
		for (int p = 0; p < 3; p++) begin
			clock_master_sel_i <= (p < 2);
			clock_polarity_sel_i <= p[0];
			blen = (p < 2) ? 5'h04 : 5'h08;
			step(2);
			put(c, 2);
			frames(c, 2);
			x = transfer_clock_pin_o;
			step(2);
			check({7'h00, transfer_clock_pin_oe_o, transfer_clock_pin_o ^ x},
				(p < 2) ? 9'h003 : 9'h000);
		end
		tx_en_i <= 1'h0;
		step(1);
		data_valid_i <= 1'h1;
		step(40);
		data_valid_i <= 1'h0;
		check({6'h00, data_ready_o, buf_empty_o, serial_out_pin_oe_o}, 9'h002);
		for (int v = 0; v < 2; v++) begin
			rx_stop_valid_i <= 1'h1;
			rx_first_stop_i <= v[0];
			step(1);
			rx_stop_valid_i <= 1'h0;
			step(3);
			check({8'h00, framing_error_o}, {8'h00, ~v[0]});
		end
		wrap_up();
	end
endmodule

/* File: src/serial_frame_pkg.sv */
// Types shared by the serial frame transmitter.
package serial_frame_pkg;

	typedef logic [8:0] char_t;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_PARITY,
		TX_STOP1,
		TX_STOP2
	} tx_state_t;

endpackage

/* File: src/serial_frame_regs.svh */
// Named constants for the serial frame transmitter.
`ifndef SERIAL_FRAME_REGS_SVH
`define SERIAL_FRAME_REGS_SVH

`define CHAR_SIZE_8 3'h3
`define CHAR_SIZE_9 3'h7
`define CHAR_BITS_MIN 4'h5
`define CHAR_BITS_8 4'h8
`define CHAR_BITS_9 4'h9
`define PARITY_EN_BIT 1
`define PARITY_ODD_BIT 0
`define PRESC_NORMAL 4'hF
`define PRESC_DOUBLE 4'h7
`define PRESC_RESET 4'h0
`define LINE_IDLE 1'h1
`define LINE_START 1'h0
`define LINE_STOP 1'h1
`define DATA_MSB 8

`endif

/* File: src/serial_frame_transmitter.sv */
// Transmit half of a serial port with shared frame format and stop-bit check.
// What this block does
// RQ1 - Frame is start bit, then data LSB first up to nine bits.
// RQ2 - Parity bit, when enabled, sits after last data bit, before first stop.
// RQ3 - After a frame, start the next at once or idle the line high.
// RQ4 - One frame format setting serves transmitter and receiver alike.
// RQ5 - Software leaves the frame format alone while a transfer runs.
// RQ6 - Stop select appends one or two stop bits per frame.
// RQ7 - Receiver checks only the first stop bit; framing error when it is zero.
// RQ8 - Parity is XOR of data bits for even, its inverse for odd.
// RQ9 - Software sets divisor, format and enable before any transfer.
// RQ10 - Software checks done flags before reinit and clears done before writes.
// RQ11 - An enabled transmitter owns the serial output pin.
// RQ12 - Synchronous mode takes the transfer clock pin to time transmission.
// RQ13 - Writing a character to the data buffer queues and starts transmission.
// RQ14 - Buffered character moves to shifter when idle or right after last stop.
// RQ15 - Shifter sends a whole frame at baud divisor rate or transfer clock.
// RQ16 - Upper bits beyond the character size are ignored.
// RQ17 - Software writes the ninth bit before the low byte.
// RQ18 - Software writes only when the buffer-empty flag shows room.
// RQ19 - Software configures rate, mode and format before transmitting.
// RQ20 - Character size allows five to nine data bits.
// RQ21 - Bit clock is baud tick over 16, 8 or 2 by mode.
// RQ22 - Sync data changes on one transfer-clock edge, polarity picks which.
// RQ23 - Buffer-empty flag is set when no character waits for the shifter.
// RQ24 - Ninth bit is captured together with the low byte at write time.
// RQ25 - Start bit low and stop bits high, each one full bit period.
`include "serial_frame_regs.svh"

module serial_frame_transmitter #(
	parameter int DIV_W = 12,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Configuration shared by both directions.
	input wire logic tx_en_i,
	input wire logic [2:0] char_size_sel_i,
	input wire logic [1:0] parity_mode_sel_i,
	input wire logic two_stop_sel_i,
	input wire logic double_speed_sel_i,
	input wire logic sync_mode_sel_i,
	input wire logic clock_master_sel_i,
	input wire logic clock_polarity_sel_i,
	input wire logic [DIV_W-1:0] baud_divisor_i,
	input wire logic baud_divisor_load_i,
	// Character writes into the data buffer.
	input wire logic data_valid_i,
	input wire logic [7:0] data_buffer_port_i,
	input wire logic tx_ninth_bit_i,
	output logic data_ready_o,
	// Transmit status.
	output logic buf_empty_o,
	output logic tx_done_flag_o,
	input wire logic tx_done_clr_i,
	output logic tx_busy_o,
	// Serial line and transfer clock pin.
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	input wire logic transfer_clock_pin_i,
	output logic transfer_clock_pin_o,
	output logic transfer_clock_pin_oe_o,
	// First stop bit sampled by the receive side.
	input wire logic rx_stop_valid_i,
	input wire logic rx_first_stop_i,
	output logic framing_error_o
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	function automatic logic [3:0] char_bits(input logic [2:0] code);
		logic [3:0] n;
		n = `CHAR_BITS_8;
		unique case (code)
			3'h0, 3'h1, 3'h2, 3'h3: n = `CHAR_BITS_MIN + {1'h0, code}; // RQ20
			`CHAR_SIZE_9: n = `CHAR_BITS_9;
			default: n = `CHAR_BITS_8;
		endcase
		return n;
	endfunction

	function automatic serial_frame_pkg::char_t char_mask(input logic [3:0] nbits);
		serial_frame_pkg::char_t m;
		m = '0;
		for (int i = 0; i <= `DATA_MSB; i++) begin
			m[i] = (4'(i) < nbits);
		end
		return m;
	endfunction

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Baud generator and bit timing.
	logic [DIV_W-1:0] baud_cnt_reg;
	logic baud_tick;
	logic [3:0] presc_reg;
	logic [3:0] presc_limit;
	logic xck_reg;
	logic xck_s1_reg;
	logic xck_s2_reg;
	logic xck_s3_reg;
	logic xck_flt_reg;
	logic xck_flt_next;
	logic bit_tick;

	// Buffer and shifter.
	serial_frame_pkg::char_t mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic push;
	logic pop;
	logic frame_end;
	serial_frame_pkg::char_t head_masked;
	serial_frame_pkg::tx_state_t state_reg;
	serial_frame_pkg::char_t shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] nbits_reg;
	logic parity_reg;

	// Output flops.
	logic ready_reg;
	logic empty_reg;
	logic done_reg;
	logic busy_reg;
	logic line_reg;
	logic pin_en_reg;
	logic xck_oe_reg;
	logic fe_reg;

	assign baud_tick = (baud_cnt_reg == '0);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			baud_cnt_reg <= '0;
		end else if (baud_divisor_load_i || baud_tick) begin
			baud_cnt_reg <= baud_divisor_i;
		end else begin
			baud_cnt_reg <= baud_cnt_reg - DIV_W'(1);
		end
	end

	assign presc_limit = double_speed_sel_i ? `PRESC_DOUBLE : `PRESC_NORMAL;

	// Asynchronous bit clock divides baud ticks by 16, or by 8 at double speed.
	always_ff @(posedge mclk_i) begin
		if (rst_i || sync_mode_sel_i) begin
			presc_reg <= `PRESC_RESET;
		end else if (baud_tick) begin
			presc_reg <= (presc_reg >= presc_limit) ? `PRESC_RESET : presc_reg + 4'h1; // RQ21
		end
	end

	// Master clock toggles on every baud tick, giving the divide by two.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			xck_reg <= 1'h0;
		end else if (!(sync_mode_sel_i && clock_master_sel_i)) begin
			xck_reg <= clock_polarity_sel_i;
		end else if (baud_tick) begin
			xck_reg <= ~xck_reg; // RQ21
		end
	end

	// The slave clock counts a change only once the second and third stages agree.
	assign xck_flt_next = (xck_s2_reg == xck_s3_reg) ? xck_s3_reg : xck_flt_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			xck_s1_reg <= 1'h0;
			xck_s2_reg <= 1'h0;
			xck_s3_reg <= 1'h0;
			xck_flt_reg <= 1'h0;
		end else begin
			xck_s1_reg <= transfer_clock_pin_i;
			xck_s2_reg <= xck_s1_reg;
			xck_s3_reg <= xck_s2_reg;
			xck_flt_reg <= xck_flt_next;
		end
	end

	// With polarity zero data changes on the rising edge, otherwise on the falling one.
	always_comb begin
		if (!sync_mode_sel_i) begin
			bit_tick = baud_tick && (presc_reg >= presc_limit); // RQ15
		end else if (clock_master_sel_i) begin
			bit_tick = baud_tick && (xck_reg == clock_polarity_sel_i); // RQ22
		end else begin
			bit_tick = (xck_flt_next != xck_flt_reg) && (xck_flt_next == ~clock_polarity_sel_i); // RQ22
		end
	end

	// Buffer control; a pop is only ever taken on a bit tick.
	always_comb begin
		frame_end = bit_tick && ((state_reg == serial_frame_pkg::TX_STOP2) ||
			((state_reg == serial_frame_pkg::TX_STOP1) && !two_stop_sel_i));
		push = data_valid_i && ready_reg; // RQ13
		pop = bit_tick && (count_reg != '0) &&
			((state_reg == serial_frame_pkg::TX_IDLE) || frame_end); // RQ14
		count_next = count_reg + CW'(push) - CW'(pop);
		head_masked = mem_reg[rd_ptr_reg] & char_mask(char_bits(char_size_sel_i)); // RQ16
	end

	// The ninth bit is stored with the low byte so later changes cannot alter it.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= {tx_ninth_bit_i, data_buffer_port_i}; // RQ24
				wr_ptr_reg <= next_ptr(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= next_ptr(rd_ptr_reg);
			end
			count_reg <= count_next;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ready_reg <= 1'h0;
			empty_reg <= 1'h1;
		end else begin
			ready_reg <= tx_en_i && (count_next < CW'(DEPTH));
			empty_reg <= (count_next == '0); // RQ23
		end
	end

	// Frame sequencer; start, parity and each stop state last one bit period, data lasts one per data bit.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg <= serial_frame_pkg::TX_IDLE;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			nbits_reg <= `CHAR_BITS_8;
			parity_reg <= 1'h0;
			line_reg <= `LINE_IDLE;
		end else if (pop) begin
			state_reg <= serial_frame_pkg::TX_START;
			shift_reg <= head_masked;
			nbits_reg <= char_bits(char_size_sel_i); // RQ4
			parity_reg <= (^head_masked) ^ parity_mode_sel_i[`PARITY_ODD_BIT]; // RQ8
			bit_cnt_reg <= '0;
			line_reg <= `LINE_START; // RQ25
		end else if (frame_end) begin
			state_reg <= serial_frame_pkg::TX_IDLE;
			line_reg <= `LINE_IDLE; // RQ3
		end else if (bit_tick) begin
			unique case (state_reg)
				serial_frame_pkg::TX_IDLE: begin
					line_reg <= `LINE_IDLE;
				end
				serial_frame_pkg::TX_START: begin
					state_reg <= serial_frame_pkg::TX_DATA;
					line_reg <= shift_reg[0]; // RQ1
					shift_reg <= shift_reg >> 1;
				end
				serial_frame_pkg::TX_DATA: begin
					if (bit_cnt_reg + 4'h1 >= nbits_reg) begin
						if (parity_mode_sel_i[`PARITY_EN_BIT]) begin
							state_reg <= serial_frame_pkg::TX_PARITY;
							line_reg <= parity_reg; // RQ2
						end else begin
							state_reg <= serial_frame_pkg::TX_STOP1;
							line_reg <= `LINE_STOP; // RQ25
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						line_reg <= shift_reg[0]; // RQ1
						shift_reg <= shift_reg >> 1;
					end
				end
				serial_frame_pkg::TX_PARITY: begin
					state_reg <= serial_frame_pkg::TX_STOP1;
					line_reg <= `LINE_STOP;
				end
				serial_frame_pkg::TX_STOP1: begin
					state_reg <= serial_frame_pkg::TX_STOP2; // RQ6
					line_reg <= `LINE_STOP;
				end
				serial_frame_pkg::TX_STOP2: begin
					line_reg <= `LINE_STOP;
				end
			endcase
		end
	end

	// Done is set when the last stop bit ends with nothing queued; a set beats a clear.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			done_reg <= 1'h0;
		end else if (frame_end && (count_reg == '0)) begin
			done_reg <= 1'h1;
		end else if (tx_done_clr_i) begin
			done_reg <= 1'h0;
		end
	end

	// Disabling waits for queued and shifting characters, so the pin stays owned.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin_en_reg <= 1'h0;
			busy_reg <= 1'h0;
			xck_oe_reg <= 1'h0;
		end else begin
			pin_en_reg <= tx_en_i || (count_next != '0) || (state_reg != serial_frame_pkg::TX_IDLE) ||
				pop; // RQ11
			busy_reg <= (count_next != '0) || (state_reg != serial_frame_pkg::TX_IDLE) || pop;
			xck_oe_reg <= sync_mode_sel_i && clock_master_sel_i; // RQ12
		end
	end

	// Only the first stop bit is offered by the receive side; a second is never examined.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fe_reg <= 1'h0;
		end else if (rx_stop_valid_i) begin
			fe_reg <= (rx_first_stop_i == `LINE_START); // RQ7
		end
	end

	assign data_ready_o = ready_reg;
	assign buf_empty_o = empty_reg;
	assign tx_done_flag_o = done_reg;
	assign tx_busy_o = busy_reg;
	assign serial_out_pin_o = line_reg;
	assign serial_out_pin_oe_o = pin_en_reg;
	assign transfer_clock_pin_o = xck_reg;
	assign transfer_clock_pin_oe_o = xck_oe_reg;
	assign framing_error_o = fe_reg;

endmodule
